// [logic/bas_pkg.sv]
package bas_pkg;
  // Operation select codes from the instruction decoder
  typedef enum logic [2:0] {
    BAS_OP_NONE,
    BAS_OP_LITERAL_MINUS_ACC,
    BAS_OP_LITERAL_XOR_ACC,
    BAS_OP_REG_MINUS_ACC,
    BAS_OP_REG_XOR_ACC,
    BAS_OP_NIBBLE_EXCHANGE
  } bas_op_e;

  localparam int BAS_DATA_W = 8;
  localparam int BAS_ADDR_W = 7;
  localparam int BAS_NIB_LO_MSB = 3;
  localparam int BAS_NIB_HI_LSB = 4;
  localparam int BAS_REG_DEPTH = 128;
  localparam logic [7:0] BAS_ACC_RESET = 8'h00;
  localparam logic BAS_FLAG_RESET = 1'b0;
  localparam logic BAS_DEST_ACC = 1'b0;
  localparam logic BAS_DEST_REG = 1'b1;
  localparam logic [7:0] BAS_ZERO_BYTE = 8'h00;
endpackage

// [logic/bas_regfile.sv]
`timescale 1ns/1ps
// Register file, 128 bytes, registered read port
module bas_regfile
  import bas_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic [BAS_ADDR_W-1:0] rd_addr_i,
  output logic [BAS_DATA_W-1:0] rd_data_o,
  input wire logic wr_en_i,
  input wire logic [BAS_ADDR_W-1:0] wr_addr_i,
  input wire logic [BAS_DATA_W-1:0] wr_data_i
);
  // Power-up contents cleared so that register operands are never unknown
  logic [BAS_DATA_W-1:0] mem [BAS_REG_DEPTH] = '{default: BAS_ZERO_BYTE};

  // Write port
  always_ff @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read
  always_ff @(posedge ref_clk_i) begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // bas_regfile

// [logic/bas_alu.sv]
`timescale 1ns/1ps
// Overview of operation
// - Literal-minus-acc puts literal minus accumulator in the accumulator and updates all three flags.
// - Literal-xor-acc puts accumulator xor literal in the accumulator and updates only the zero flag.
// - Reg-minus-acc subtracts the accumulator from the addressed register and updates all three flags.
// - Reg-minus-acc sends the difference to the accumulator when target is 0, else to the register.
// - Reg-xor-acc xors the accumulator with the addressed register and updates only the zero flag.
// - Reg-xor-acc sends the result to the accumulator when target is 0, else to the register.
// - Nibble exchange swaps the register's nibbles and leaves every flag unchanged.
// - Nibble exchange sends the swapped byte to the accumulator when target is 0, else to the register.
module bas_alu
  import bas_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic op_valid_i,
  input wire bas_op_e op_i,
  input wire logic [BAS_DATA_W-1:0] imm_value_i,
  input wire logic [BAS_ADDR_W-1:0] reg_operand_i,
  input wire logic result_target_i,
  input wire logic [BAS_ADDR_W-1:0] peek_addr_i,
  output logic [BAS_DATA_W-1:0] peek_data_o,
  output logic [BAS_DATA_W-1:0] accumulator_o,
  output logic borrow_out_flag_o,
  output logic nibble_borrow_flag_o,
  output logic result_null_flag_o,
  output logic busy_o,
  output logic done_o
);
  typedef enum logic [1:0] {
    BAS_ST_IDLE,
    BAS_ST_READ,
    BAS_ST_EXEC
  } bas_state_e;

  bas_state_e state;
  bas_op_e op_hold;
  logic [BAS_DATA_W-1:0] imm_hold;
  logic [BAS_ADDR_W-1:0] addr_hold;
  logic target_hold;
  logic [BAS_DATA_W-1:0] accumulator;
  logic borrow_out_flag;
  logic nibble_borrow_flag;
  logic result_null_flag;
  logic done;
  logic [BAS_DATA_W-1:0] reg_data;
  logic [BAS_ADDR_W-1:0] rd_addr;
  logic wr_en;
  logic [BAS_DATA_W-1:0] next_result;
  logic [BAS_DATA_W-1:0] operand;
  logic [BAS_DATA_W:0] diff;
  logic [BAS_NIB_HI_LSB:0] diff_lo;
  logic is_sub;
  logic is_xor;
  logic to_reg;

  // True for ops that take a register-file operand
  function automatic logic bas_uses_reg(input bas_op_e op);
    return (op == BAS_OP_REG_MINUS_ACC) || (op == BAS_OP_REG_XOR_ACC) || (op == BAS_OP_NIBBLE_EXCHANGE);
  endfunction

  // Read address: held during execution, else peek port
  assign rd_addr = (state == BAS_ST_IDLE) ? peek_addr_i : addr_hold;

  bas_regfile u_regfile (
    .ref_clk_i(ref_clk_i),
    .rd_addr_i(rd_addr),
    .rd_data_o(reg_data),
    .wr_en_i(wr_en),
    .wr_addr_i(addr_hold),
    .wr_data_i(next_result)
  );

  // Operand select and result computation
  always_comb begin
    operand = bas_uses_reg(op_hold) ? reg_data : imm_hold;
    diff = {1'b0, operand} - {1'b0, accumulator};
    diff_lo = {1'b0, operand[BAS_NIB_LO_MSB:0]} - {1'b0, accumulator[BAS_NIB_LO_MSB:0]};
    is_sub = (op_hold == BAS_OP_LITERAL_MINUS_ACC) || (op_hold == BAS_OP_REG_MINUS_ACC);
    is_xor = (op_hold == BAS_OP_LITERAL_XOR_ACC) || (op_hold == BAS_OP_REG_XOR_ACC);
    case (op_hold)
      BAS_OP_LITERAL_MINUS_ACC, BAS_OP_REG_MINUS_ACC: next_result = diff[BAS_DATA_W-1:0];
      BAS_OP_LITERAL_XOR_ACC, BAS_OP_REG_XOR_ACC: next_result = operand ^ accumulator;
      BAS_OP_NIBBLE_EXCHANGE: next_result = {operand[BAS_NIB_LO_MSB:0], operand[BAS_DATA_W-1:BAS_NIB_HI_LSB]};
      default: next_result = accumulator;
    endcase
  end

  // Register destination only for register ops with target 1
  assign to_reg = bas_uses_reg(op_hold) && (target_hold == BAS_DEST_REG);
  assign wr_en = (state == BAS_ST_EXEC) && to_reg;

  // Sequencer: capture, read operand, execute
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= BAS_ST_IDLE;
    end else begin
      case (state)
        BAS_ST_IDLE: begin
          if (op_valid_i && (op_i != BAS_OP_NONE)) begin
            state <= BAS_ST_READ;
          end
        end
        BAS_ST_READ: state <= BAS_ST_EXEC;
        default: state <= BAS_ST_IDLE;
      endcase
    end
  end

  // Instruction capture
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      op_hold <= BAS_OP_NONE;
      imm_hold <= BAS_ZERO_BYTE;
      addr_hold <= '0;
      target_hold <= BAS_DEST_ACC;
    end else if (state == BAS_ST_IDLE && op_valid_i) begin
      op_hold <= op_i;
      imm_hold <= imm_value_i;
      addr_hold <= reg_operand_i;
      target_hold <= result_target_i;
    end
  end

  // Accumulator write-back
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      accumulator <= BAS_ACC_RESET;
    end else if (state == BAS_ST_EXEC && !to_reg) begin
      accumulator <= next_result;
    end
  end

  // Status flags
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      borrow_out_flag <= BAS_FLAG_RESET;
      nibble_borrow_flag <= BAS_FLAG_RESET;
      result_null_flag <= BAS_FLAG_RESET;
    end else if (state == BAS_ST_EXEC) begin
      if (is_sub) begin
        borrow_out_flag <= ~diff[BAS_DATA_W];
        nibble_borrow_flag <= ~diff_lo[BAS_NIB_HI_LSB];
      end
      if (is_sub || is_xor) begin
        result_null_flag <= (next_result == BAS_ZERO_BYTE);
      end
    end
  end

  // Completion pulse
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      done <= 1'b0;
    end else begin
      done <= (state == BAS_ST_EXEC);
    end
  end

  assign busy_o = (state != BAS_ST_IDLE);
  assign done_o = done;
  assign accumulator_o = accumulator;
  assign borrow_out_flag_o = borrow_out_flag;
  assign nibble_borrow_flag_o = nibble_borrow_flag;
  assign result_null_flag_o = result_null_flag;
  assign peek_data_o = reg_data;
endmodule // bas_alu

// [verification/bas_alu_props.sv]
`timescale 1ns/1ps
// Timing and flag checks on the ALU ports
module bas_alu_props
  import bas_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic op_valid_i,
  input wire bas_op_e op_i,
  input wire logic [7:0] imm_value_i,
  input wire logic [7:0] accumulator_o,
  input wire logic borrow_out_flag_o,
  input wire logic nibble_borrow_flag_o,
  input wire logic result_null_flag_o,
  input wire logic busy_o,
  input wire logic done_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic take;
  logic [7:0] exp_acc;
  assign take = op_valid_i && !busy_o && op_i != BAS_OP_NONE;
  // Literal result captured when the request is taken
  always_ff @(posedge ref_clk_i)
    if (take)
      exp_acc <= (op_i == BAS_OP_LITERAL_XOR_ACC) ? accumulator_o ^ imm_value_i : imm_value_i - accumulator_o;
  a_take_busy: assert property (take |=> busy_o) else $error("busy missing");
  a_done_bound: assert property (take |-> ##[2:3] done_o) else $error("done late");
  a_done_pulse: assert property (done_o |=> !done_o) else $error("done long");
  a_idle_stay: assert property (!busy_o && !take |=> !busy_o) else $error("busy unasked");
  a_acc_hold: assert property (!busy_o && !take |=> $stable(accumulator_o)) else $error("acc moved");
  a_swap_flags: assert property (take && op_i == BAS_OP_NIBBLE_EXCHANGE |=>
    $stable({borrow_out_flag_o, nibble_borrow_flag_o, result_null_flag_o})[*3]) else $error("swap flags");
  a_xor_carry: assert property (take && op_i inside {BAS_OP_LITERAL_XOR_ACC, BAS_OP_REG_XOR_ACC} |=>
    $stable({borrow_out_flag_o, nibble_borrow_flag_o})[*3]) else $error("xor carry");
  a_lit_result: assert property (take && op_i inside {BAS_OP_LITERAL_MINUS_ACC, BAS_OP_LITERAL_XOR_ACC} |->
    ##[2:3] (done_o && accumulator_o == exp_acc)) else $error("literal result");
endmodule // bas_alu_props
bind bas_alu bas_alu_props u_props (.ref_clk_i, .reset_n_i, .op_valid_i, .op_i, .imm_value_i, .accumulator_o,
  .borrow_out_flag_o, .nibble_borrow_flag_o, .result_null_flag_o, .busy_o, .done_o);

// [verification/byte_alu_sub_xor_swap_bench.sv]
`timescale 1ns/1ps
module byte_alu_sub_xor_swap_bench;
  import bas_pkg::*;
  logic ref_clk_i = 0, reset_n_i = 0, op_valid_i = 0, result_target_i = 0;
  bas_op_e op_i = BAS_OP_NONE;
  logic [7:0] imm_value_i = 8'h00, peek_data_o, accumulator_o, a = 8'h00, m;
  logic [6:0] reg_operand_i = 7'h7f, peek_addr_i = 7'h7f;
  logic borrow_out_flag_o, nibble_borrow_flag_o, result_null_flag_o, busy_o, done_o;
  logic [2:0] f = 3'h0;
  int err_count = 0, n_checks = 0;
  bas_alu dut (.ref_clk_i, .reset_n_i, .op_valid_i, .op_i, .imm_value_i, .reg_operand_i, .result_target_i,
    .peek_addr_i, .peek_data_o, .accumulator_o, .borrow_out_flag_o, .nibble_borrow_flag_o,
    .result_null_flag_o, .busy_o, .done_o);
  // Clock, 50 ns period
  initial forever #25 ref_clk_i = ~ref_clk_i;
  // Compare; an unknown expectation is a mismatch too
  task check(string nm, logic [7:0] got, logic [7:0] exp);
    n_checks++;
    if (got !== exp || $isunknown(exp)) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task results;
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Model one operation, issue it, wait for done, compare
  task run(bas_op_e o, logic [7:0] k, logic t);
    int i;
    logic [8:0] d;
    logic [7:0] s, res;
    s = (o < BAS_OP_REG_MINUS_ACC) ? k : m;
    res = s ^ a;
    if (o == BAS_OP_NIBBLE_EXCHANGE)
      res = {s[3:0], s[7:4]};
    else if (o == BAS_OP_LITERAL_MINUS_ACC || o == BAS_OP_REG_MINUS_ACC) begin
      d = {1'b0, s} - {1'b0, a};
      res = d[7:0];
      f[2:1] = {~d[8], s[3:0] >= a[3:0]};
    end
    if (o != BAS_OP_NIBBLE_EXCHANGE)
      f[0] = res == 8'h00;
    if (t && o > BAS_OP_LITERAL_XOR_ACC)
      m = res;
    else
      a = res;
    op_i = o;
    imm_value_i = k;
    result_target_i = t;
    op_valid_i = 1;
    @(negedge ref_clk_i);
    op_valid_i = 0;
    for (i = 0; i < 6 && done_o !== 1'b1; i++)
      @(negedge ref_clk_i);
    if (done_o !== 1'b1) begin
      err_count++;
      results;
    end
    @(negedge ref_clk_i);
    check("acc", accumulator_o, a);
    check("flags", {5'h00, borrow_out_flag_o, nibble_borrow_flag_o, result_null_flag_o}, {5'h00, f});
    if (o > BAS_OP_LITERAL_XOR_ACC)
      check("reg", peek_data_o, m);
  endtask
  // Empty code with strobe must not start anything
  task t_refuse;
    op_valid_i = 1;
    @(negedge ref_clk_i);
    op_valid_i = 0;
    check("busy", {7'h00, busy_o}, 8'h00);
  endtask
  task t_literal;
    run(BAS_OP_LITERAL_XOR_ACC, 8'h5a, 1'b1);
    run(BAS_OP_LITERAL_MINUS_ACC, 8'h5a, 1'b1);
    run(BAS_OP_LITERAL_XOR_ACC, 8'hff, 1'b0);
    run(BAS_OP_LITERAL_MINUS_ACC, 8'h10, 1'b0);
    run(BAS_OP_LITERAL_MINUS_ACC, 8'h38, 1'b0);
  endtask
  // Top register, both destinations of every register operation
  task t_reg;
    m = peek_data_o;
    run(BAS_OP_REG_XOR_ACC, 8'h00, 1'b1);
    run(BAS_OP_REG_MINUS_ACC, 8'h00, 1'b0);
    run(BAS_OP_REG_MINUS_ACC, 8'h00, 1'b1);
    run(BAS_OP_NIBBLE_EXCHANGE, 8'h00, 1'b0);
    run(BAS_OP_NIBBLE_EXCHANGE, 8'h00, 1'b1);
    run(BAS_OP_REG_XOR_ACC, 8'h00, 1'b0);
  endtask
  initial begin
    repeat (8) @(negedge ref_clk_i);
    reset_n_i = 1;
    t_refuse;
    t_literal;
    t_reg;
    results;
  end
endmodule // byte_alu_sub_xor_swap_bench
